// [hpm_pkg.sv]
// Shared constants and types of the switch power management block
package hpm_pkg;
  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int NP = 7;
  localparam int ND = 6;
  localparam int NB = 8;
  localparam int DW = 32;
  localparam int TW = 16;
  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_NS = 8;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [TW-1:0] PME_TO_RST = 16'h03e8;
  localparam logic [TW-1:0] ACK_TO_RST = 16'h03e8;
  // ****************************************************************
  // Register map, byte addresses
  // ****************************************************************
  localparam logic [7:0] A_PMCTL = 8'h00;
  localparam logic [7:0] A_PMETMR = 8'h04;
  localparam logic [7:0] A_ACKTMR = 8'h08;
  localparam logic [7:0] A_SW_CTRL = 8'h80;
  localparam logic [7:0] A_BCAP = 8'h84;
  localparam logic [7:0] A_AGSTAT = 8'h88;
  localparam logic [7:0] A_BDV = 8'ha0;
  localparam int PORT_SH = 4;
  // ****************************************************************
  // Fields
  // ****************************************************************
  localparam int F_PST = 0;
  localparam int F_NSR = 3;
  localparam int F_CFG = 4;
  localparam int F_PME_ST = 15;
  localparam int F_UNLK = 0;
  localparam logic [1:0] PST_D0 = 2'h0;
  localparam logic [1:0] PST_D3 = 2'h3;
  localparam logic NSR_RST = 1'b1;
  localparam logic [DW-1:0] BCAP_RST = 32'h0000_0000;
  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {PS_D0U, PS_D0A, PS_D3H, PS_D3C} hpm_pstate_t;
  typedef enum logic [2:0] {K_CFG0, K_MSG_SELF, K_REQ, K_CPL_SELF,
                            K_CPL_THRU} hpm_kind_t;
  typedef enum logic [2:0] {X_NONE, X_PROCESS, X_UR, X_UC, X_ROUTE,
                            X_DROP} hpm_act_t;
  typedef enum logic [1:0] {AG_IDLE, AG_WAIT, AG_DONE} hpm_agg_t;
endpackage : hpm_pkg

// [hpm_bdv_if.sv]
// Carrier between the block and its budget data store
`timescale 1ns/1ps
interface hpm_bdv_if;
  import hpm_pkg::*;
  logic          we;
  logic [2:0]    addr;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdata;
  modport ctl (output we, output addr, output wdata, input rdata);
  modport mem (input we, input addr, input wdata, output rdata);
endinterface : hpm_bdv_if

// [hpm_bdv_mem.sv]
// Eight-word budget data store with registered read data
`timescale 1ns/1ps
module hpm_bdv_mem (
  input wire logic mclk,
  input wire logic rst,
  hpm_bdv_if.mem   bus
);
  import hpm_pkg::*;
  logic [DW-1:0] mem [NB];

  always_ff @(posedge mclk) begin
    if (bus.we) begin
      mem[bus.addr] <= bus.wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      bus.rdata <= '0;
    end else begin
      bus.rdata <= mem[bus.addr];
    end
  end
endmodule : hpm_bdv_mem

// [hpm_power_mgmt.sv]
// Per-port power management, turn-off aggregation and budget registers
`timescale 1ns/1ps
//
// How it works
// - Each downstream bridge state acts only on its own port.
// - A bridge in D3hot requests L1 independent of other ports.
// - Upstream in D3hot plus turn-off acks puts the switch low power.
// - Four states per bridge: D0 uninit, D0 active, D3hot, D3cold.
// - Reset gives D0 uninit; software configuration gives D0 active.
// - D3 write moves D0 active to D3hot; D0 write moves D3hot to D0 uninit.
// - Leaving D3hot resets nothing; no-soft-reset bit defaults set.
// - In D3hot type 0 config and messages to bridge are processed.
// - Other primary requests and all secondary requests become UR.
// - In D3hot TLP-caused errors report; other errors are dropped.
// - Completions to the bridge are unexpected; passing ones route.
// - Downstream hot-plug PME allowed in D3hot, never from D3cold.
// - Uncleared PME status past the time-out resends and restarts.
// - Upstream turn-off is forwarded on every active downstream port.
// - Upstream ack and L2/L3 only once every active port acked.
// - Upstream TLP before ack abandons; after ack TLPs are dropped.
// - Abandoning TLP is handled; a port out of L0 retrains first.
// - Abandon keeps downstream exchange; later TLPs retrain the port.
// - Downstream ack time-out counts as ack and enters L2/L3.
// - Back in D0 uninit instead of D3cold, PME generation resumes.
// - Budget header reads zero unless initialised; read-only from the register bus.
// - Budget data writable from the register bus only while the unlock bit is set.
module hpm_power_mgmt (
  input  wire logic                 mclk,
  input  wire logic                 rst,
  input  wire logic [7:0]           reg_addr,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic [31:0]               reg_rdata,
  input  wire logic                 init_we,
  input  wire logic [7:0]           init_addr,
  input  wire logic [31:0]          init_wdata,
  input  wire logic [hpm_pkg::NP-1:0] power_removed,
  input  wire logic                 tlp_valid,
  input  wire logic [2:0]           tlp_port,
  input  wire logic                 tlp_sec,
  input  wire hpm_pkg::hpm_kind_t   tlp_kind,
  input  wire logic [2:0]           tlp_dest,
  output hpm_pkg::hpm_act_t         tlp_act,
  input  wire logic                 err_valid,
  input  wire logic [2:0]           err_port,
  input  wire logic                 err_from_tlp,
  output logic                      err_msg,
  input  wire logic [hpm_pkg::ND-1:0] hp_event,
  output logic [hpm_pkg::ND-1:0]    pme_tx,
  input  wire logic                 turnoff_rx,
  input  wire logic [hpm_pkg::ND-1:0] dn_active,
  output logic [hpm_pkg::ND-1:0]    turnoff_tx,
  input  wire logic [hpm_pkg::ND-1:0] ack_rx,
  output logic [hpm_pkg::ND-1:0]    dn_l23,
  output logic [hpm_pkg::ND-1:0]    dn_retrain,
  output logic                      up_ack_tx,
  output logic                      up_l23,
  output logic                      switch_low,
  output logic [hpm_pkg::NP-1:0]    l1_req
);
  import hpm_pkg::*;

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  hpm_pstate_t   pst [NP];
  logic [NP-1:0] d3h;
  logic [TW-1:0] pme_to [NP];
  logic [TW-1:0] ack_to [NP];
  logic [ND:0]   pme_status_bit;
  logic          unlock;
  logic [DW-1:0] bcap;
  logic [DW-1:0] rdata_q;
  logic          rd_mem_q;
  logic [7:0]    tick_cnt;
  wire  logic    tick = (tick_cnt == 8'(TICK_CYC - 1));
  wire  logic [2:0] a_port = reg_addr[PORT_SH+2:PORT_SH];
  wire  logic    a_pp = (reg_addr[7] == 1'b0) && (a_port < 3'(NP));
  wire  logic [7:0] a_off = {4'h0, reg_addr[3:0]};
  wire  logic    a_bdv = (reg_addr[7:5] == A_BDV[7:5]);
  wire  logic    wr_pm = reg_wr && a_pp && (a_off == A_PMCTL);
  wire  logic [1:0] w_pst = reg_wdata[F_PST+1:F_PST];
  hpm_bdv_if bdv ();

  hpm_bdv_mem u_mem (
    .mclk (mclk),
    .rst  (rst),
    .bus  (bdv)
  );

  // Init port has priority so boot loading cannot be blocked by lock
  assign bdv.we = (init_we && init_addr[7:5] == A_BDV[7:5])
                  || (reg_wr && a_bdv && unlock);
  assign bdv.addr = init_we ? init_addr[4:2] : reg_addr[4:2];
  assign bdv.wdata = init_we ? init_wdata : reg_wdata;

  always_ff @(posedge mclk) begin
    if (rst) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick ? '0 : tick_cnt + 8'h01;
    end
  end

  // ****************************************************************
  // Bridge power states, one per port
  // ****************************************************************
  genvar p;
  generate
    for (p = 0; p < NP; p++) begin : g_port
      wire logic sel = wr_pm && (a_port == 3'(p));
      hpm_pstate_t next_pst;
      always_comb begin
        next_pst = pst[p];
        unique case (pst[p])
          PS_D0U: if (sel && reg_wdata[F_CFG]) next_pst = PS_D0A;
          PS_D0A: if (sel && w_pst == PST_D3) next_pst = PS_D3H;
          PS_D3H: begin
            if (power_removed[p]) next_pst = PS_D3C;
            else if (sel && w_pst == PST_D0) next_pst = PS_D0U;
          end
          PS_D3C: next_pst = PS_D3C;
        endcase
      end
      // Only the state changes; timers and registers keep context
      always_ff @(posedge mclk) begin
        if (rst) begin
          pst[p] <= PS_D0U;
          pme_to[p] <= PME_TO_RST;
          ack_to[p] <= ACK_TO_RST;
        end else begin
          pst[p] <= next_pst;
          if (reg_wr && a_pp && a_port == 3'(p) && a_off == A_PMETMR) begin
            pme_to[p] <= reg_wdata[TW-1:0];
          end
          if (reg_wr && a_pp && a_port == 3'(p) && a_off == A_ACKTMR) begin
            ack_to[p] <= reg_wdata[TW-1:0];
          end
        end
      end
      assign d3h[p] = (pst[p] == PS_D3H);
      assign l1_req[p] = d3h[p];
    end
  endgenerate
  assign pme_status_bit[0] = 1'b0;

  // ****************************************************************
  // Hot-plug PME with retry, and turn-off per downstream port
  // ****************************************************************
  hpm_agg_t      agg;
  logic [ND-1:0] pend;
  logic [ND-1:0] acked;
  logic [ND-1:0] snap;
  wire  logic    to_go = turnoff_rx;
  wire  logic    up_tlp = tlp_valid && tlp_port == 3'h0 && !tlp_sec;
  generate
    for (p = 1; p < NP; p++) begin : g_dn
      logic [TW-1:0] pcnt;
      logic [TW-1:0] acnt;
      // D3cold has no PME; any other state may raise one
      wire logic can_pme = (pst[p] != PS_D3C);
      wire logic hp = hp_event[p-1] && can_pme;
      wire logic clr = wr_pm && a_port == 3'(p) && reg_wdata[F_PME_ST];
      wire logic pexp = pme_status_bit[p] && tick && (pcnt >= pme_to[p]);
      wire logic aexp = pend[p-1] && tick && (acnt >= ack_to[p]);
      wire logic retr = up_tlp && tlp_dest == 3'(p) && dn_l23[p-1];
      always_ff @(posedge mclk) begin
        if (rst) begin
          pme_status_bit[p] <= 1'b0;
          pcnt <= '0;
          pme_tx[p-1] <= 1'b0;
          acnt <= '0;
          pend[p-1] <= 1'b0;
          acked[p-1] <= 1'b0;
          dn_l23[p-1] <= 1'b0;
          dn_retrain[p-1] <= 1'b0;
          turnoff_tx[p-1] <= 1'b0;
        end else begin
          // Event wins over a clear in the same cycle
          pme_status_bit[p] <= hp || (pme_status_bit[p] && !clr);
          pme_tx[p-1] <= (hp && !pme_status_bit[p]) || (pexp && can_pme);
          if (hp || pexp || !pme_status_bit[p]) begin
            pcnt <= '0;
          end else if (tick) begin
            pcnt <= pcnt + 16'h0001;
          end
          turnoff_tx[p-1] <= to_go && dn_active[p-1];
          if (to_go && dn_active[p-1]) begin
            pend[p-1] <= 1'b1;
            acked[p-1] <= 1'b0;
            acnt <= '0;
          end else if (pend[p-1] && (ack_rx[p-1] || aexp)) begin
            pend[p-1] <= 1'b0;
            acked[p-1] <= 1'b1;
          end else if (tick && pend[p-1]) begin
            acnt <= acnt + 16'h0001;
          end
          if (retr) begin
            dn_l23[p-1] <= 1'b0;
          end else if (pend[p-1] && (ack_rx[p-1] || aexp)) begin
            dn_l23[p-1] <= 1'b1;
          end
          dn_retrain[p-1] <= retr;
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Upstream aggregation
  // ****************************************************************
  wire logic all_ack = ((snap & ~acked) == '0);
  hpm_agg_t next_agg;
  always_comb begin
    next_agg = agg;
    unique case (agg)
      AG_IDLE: if (to_go) next_agg = AG_WAIT;
      AG_WAIT: begin
        if (up_tlp) next_agg = AG_IDLE;
        else if (all_ack) next_agg = AG_DONE;
      end
      AG_DONE: next_agg = AG_DONE;
      default: next_agg = AG_IDLE;
    endcase
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      agg <= AG_IDLE;
      snap <= '0;
      up_ack_tx <= 1'b0;
    end else begin
      agg <= next_agg;
      if (to_go) begin
        snap <= dn_active;
      end
      up_ack_tx <= (agg == AG_WAIT) && (next_agg == AG_DONE);
    end
  end
  assign up_l23 = (agg == AG_DONE);
  assign switch_low = up_l23 && d3h[0];

  // ****************************************************************
  // TLP and error handling
  // ****************************************************************
  wire logic t_d3 = d3h[tlp_port];
  hpm_act_t next_act;
  always_comb begin
    next_act = X_NONE;
    if (tlp_valid) begin
      unique case (tlp_kind)
        K_CFG0, K_MSG_SELF: next_act = tlp_sec ? X_ROUTE : X_PROCESS;
        K_REQ: next_act = X_ROUTE;
        K_CPL_SELF: next_act = X_PROCESS;
        K_CPL_THRU: next_act = X_ROUTE;
        default: next_act = X_NONE;
      endcase
      if (t_d3) begin
        // A completion is never a request, whichever side it came from
        if (tlp_kind == K_CPL_SELF) begin
          next_act = X_UC;
        end else if (tlp_sec && tlp_kind != K_CPL_THRU) begin
          next_act = X_UR;
        end else if (tlp_kind == K_REQ) begin
          next_act = X_UR;
        end
      end
      if (up_tlp && agg == AG_DONE) begin
        next_act = X_DROP;
      end
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      tlp_act <= X_NONE;
      err_msg <= 1'b0;
    end else begin
      tlp_act <= next_act;
      err_msg <= err_valid && (err_from_tlp || !d3h[err_port]);
    end
  end

  // ****************************************************************
  // Register reads and budget header
  // ****************************************************************
  logic [DW-1:0] pp_rd;
  assign pp_rd = (a_off == A_PMCTL)
      ? {16'h0, pme_status_bit[a_port], 10'h0, pst[a_port] != PS_D0U,
         NSR_RST, 1'b0, d3h[a_port] ? PST_D3 : PST_D0}
      : (a_off == A_PMETMR) ? {16'h0, pme_to[a_port]}
      : (a_off == A_ACKTMR) ? {16'h0, ack_to[a_port]} : '0;
  always_ff @(posedge mclk) begin
    if (rst) begin
      unlock <= 1'b0;
      bcap <= BCAP_RST;
      rdata_q <= '0;
      rd_mem_q <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == A_SW_CTRL) begin
        unlock <= reg_wdata[F_UNLK];
      end
      if (init_we && init_addr == A_BCAP) begin
        bcap <= init_wdata;
      end
      rd_mem_q <= reg_rd && a_bdv;
      if (reg_rd) begin
        rdata_q <= a_pp ? pp_rd
            : (reg_addr == A_SW_CTRL) ? {31'h0, unlock}
            : (reg_addr == A_BCAP) ? bcap
            : (reg_addr == A_AGSTAT) ? {24'h0, switch_low, 1'b0,
                                        agg == AG_DONE, agg == AG_WAIT,
                                        acked[3:0]}
            : '0;
      end else begin
        rdata_q <= '0;
      end
    end
  end
  assign reg_rdata = rd_mem_q ? bdv.rdata : rdata_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_up_ack_all: assert property (@(posedge mclk) disable iff (rst)
    up_ack_tx |-> $past(all_ack) && $past(agg == AG_WAIT))
    else $error("upstream ack before all ports acked");
  chk_abandon: assert property (@(posedge mclk) disable iff (rst)
    (agg == AG_WAIT && up_tlp) |=> agg == AG_IDLE && !up_ack_tx)
    else $error("aggregation not abandoned");
  chk_fwd_off: assert property (@(posedge mclk) disable iff (rst)
    to_go |=> turnoff_tx == $past(dn_active))
    else $error("turn-off not forwarded");
  chk_d3_ur: assert property (@(posedge mclk) disable iff (rst)
    (tlp_valid && t_d3 && tlp_kind == K_REQ && !up_l23) |=> tlp_act == X_UR)
    else $error("request in D3hot not UR");
  chk_err_drop: assert property (@(posedge mclk) disable iff (rst)
    (err_valid && !err_from_tlp && d3h[err_port]) |=> !err_msg)
    else $error("non-TLP error sent in D3hot");
  chk_d3_exit: assert property (@(posedge mclk) disable iff (rst)
    (d3h[0] && wr_pm && a_port == 3'h0 && w_pst == PST_D0
     && !power_removed[0]) |=> pst[0] == PS_D0U)
    else $error("D3hot exit wrong");
  chk_lock: assert property (@(posedge mclk) disable iff (rst)
    (reg_wr && a_bdv && !unlock && !init_we) |-> !bdv.we)
    else $error("locked budget data written");
  chk_low_pwr: assert property (@(posedge mclk) disable iff (rst)
    $rose(switch_low) |-> d3h[0] && agg == AG_DONE)
    else $error("switch low power without cause");
endmodule : hpm_power_mgmt

// [hpm_far_end.sv]
// Behavioural model of the downstream devices answering a turn-off
`timescale 1ns/1ps
module hpm_far_end (
  input  wire logic                          mclk,
  input  wire logic                          rst,
  input  wire logic [hpm_pkg::ND-1:0]        turnoff_tx,
  input  wire logic [hpm_pkg::ND-1:0][7:0]   ack_dly,
  output logic      [hpm_pkg::ND-1:0]        ack_rx
);
  import hpm_pkg::*;
  // ****************************************************************
  // Per-port acknowledgement delay
  // ****************************************************************
  // Zero delay stands for a device that never answers
  logic [ND-1:0][7:0] cnt;
  always_ff @(posedge mclk) begin
    for (int i = 0; i < ND; i++) begin
      if (rst) begin
        cnt[i]    <= 8'h00;
        ack_rx[i] <= 1'b0;
      end else begin
        ack_rx[i] <= (cnt[i] == 8'h01);
        if (turnoff_tx[i])
          cnt[i] <= ack_dly[i];
        else if (cnt[i] != 8'h00)
          cnt[i] <= cnt[i] - 8'h01;
      end
    end
  end
endmodule : hpm_far_end

// [testbench.sv]
// Self-checking bench of the switch power management block
`timescale 1ns/1ps
module testbench;
  import hpm_pkg::*;
  logic mclk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00, init_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, init_wdata = 32'h0, reg_rdata;
  logic init_we = 1'b0, tlp_valid = 1'b0, tlp_sec = 1'b0;
  logic err_valid = 1'b0, err_from_tlp = 1'b0, turnoff_rx = 1'b0;
  logic [NP-1:0] power_removed = '0, l1_req;
  logic [2:0] tlp_port = 3'h0, tlp_dest = 3'h0, err_port = 3'h0;
  hpm_kind_t tlp_kind = K_CFG0;
  hpm_act_t tlp_act;
  logic err_msg, up_ack_tx, up_l23, switch_low;
  logic [ND-1:0] hp_event = '0, dn_active = '0, pme_tx, turnoff_tx;
  logic [ND-1:0] ack_rx, dn_l23, dn_retrain;
  logic [ND-1:0][7:0] ack_dly = '0;
  int err_count = 0, num_checks = 0;
  always #4 mclk = ~mclk;
  hpm_power_mgmt i_hpm_power_mgmt (.mclk(mclk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .init_we(init_we),
    .init_addr(init_addr), .init_wdata(init_wdata),
    .power_removed(power_removed), .tlp_valid(tlp_valid),
    .tlp_port(tlp_port), .tlp_sec(tlp_sec), .tlp_kind(tlp_kind),
    .tlp_dest(tlp_dest), .tlp_act(tlp_act), .err_valid(err_valid),
    .err_port(err_port), .err_from_tlp(err_from_tlp), .err_msg(err_msg),
    .hp_event(hp_event), .pme_tx(pme_tx), .turnoff_rx(turnoff_rx),
    .dn_active(dn_active), .turnoff_tx(turnoff_tx), .ack_rx(ack_rx),
    .dn_l23(dn_l23), .dn_retrain(dn_retrain), .up_ack_tx(up_ack_tx),
    .up_l23(up_l23), .switch_low(switch_low), .l1_req(l1_req));
  hpm_far_end i_hpm_far_end (.mclk(mclk), .rst(rst),
    .turnoff_tx(turnoff_tx), .ack_dly(ack_dly), .ack_rx(ack_rx));
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic finish_test;
    $display("checks=%0d errors=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test
  task automatic do_reset;
    @(posedge mclk) rst <= 1'b1;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
  endtask : do_reset
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk) begin
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
    end
    @(posedge mclk) reg_wr <= 1'b0;
  endtask : wr
  // Reads sample right after the edge that ends the data cycle
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk) begin
      reg_rd <= 1'b1;
      reg_addr <= a;
    end
    @(posedge mclk) reg_rd <= 1'b0;
    @(posedge mclk) chk(reg_rdata, e);
  endtask : rd
  task automatic tlp(input logic [2:0] p, input logic s, input hpm_kind_t k,
                     input logic [2:0] d, input hpm_act_t e);
    @(posedge mclk) begin
      tlp_valid <= 1'b1;
      tlp_port <= p;
      tlp_sec <= s;
      tlp_kind <= k;
      tlp_dest <= d;
    end
    @(posedge mclk) tlp_valid <= 1'b0;
    @(posedge mclk) chk(32'(tlp_act), 32'(e));
  endtask : tlp
  // Counts edges with any bit of the mask set on pme_tx, or ack upstream
  task automatic watch(input int cyc, input logic [ND-1:0] m,
                       output int hits);
    hits = 0;
    repeat (cyc) @(posedge mclk) hits += int'(|(pme_tx & m) || up_ack_tx);
  endtask : watch
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_regs;
    rd(8'h10, 32'h0000_0008);
    wr(8'h84, 32'hffff_ffff);
    rd(8'h84, 32'h0000_0000);
    rd(8'h7c, 32'h0000_0000);
    @(posedge mclk) begin
      init_we <= 1'b1;
      init_addr <= 8'h84;
      init_wdata <= 32'h0001_0004;
    end
    @(posedge mclk) begin
      init_addr <= 8'ha4;
      init_wdata <= 32'h0000_0011;
    end
    @(posedge mclk) init_we <= 1'b0;
    rd(8'h84, 32'h0001_0004);
    wr(8'ha4, 32'h0000_0022);
    rd(8'ha4, 32'h0000_0011);
    wr(8'h80, 32'h0000_0001);
    wr(8'ha4, 32'h0000_0055);
    rd(8'ha4, 32'h0000_0055);
    wr(8'h80, 32'h0000_0000);
    wr(8'ha4, 32'h0000_0066);
    rd(8'ha4, 32'h0000_0055);
  endtask : t_regs
  task automatic t_d3hot;
    tlp(3'h1, 1'b0, K_REQ, 3'h1, X_ROUTE);
    wr(8'h10, 32'h0000_0010);
    rd(8'h10, 32'h0000_0018);
    wr(8'h10, 32'h0000_0003);
    rd(8'h10, 32'h0000_001b);
    chk(32'(l1_req), 32'h0000_0002);
    tlp(3'h1, 1'b0, K_CFG0, 3'h1, X_PROCESS);
    tlp(3'h1, 1'b0, K_MSG_SELF, 3'h1, X_PROCESS);
    tlp(3'h1, 1'b0, K_REQ, 3'h1, X_UR);
    tlp(3'h1, 1'b1, K_REQ, 3'h1, X_UR);
    tlp(3'h1, 1'b0, K_CPL_SELF, 3'h1, X_UC);
    tlp(3'h1, 1'b1, K_CPL_THRU, 3'h1, X_ROUTE);
    tlp(3'h1, 1'b1, K_CPL_SELF, 3'h1, X_UC);
    for (int f = 1; f >= 0; f--) begin
      @(posedge mclk) begin
        err_valid <= 1'b1;
        err_port <= 3'h1;
        err_from_tlp <= f[0];
      end
      @(posedge mclk) err_valid <= 1'b0;
      @(posedge mclk) chk(32'(err_msg), 32'(f[0]));
    end
    wr(8'h10, 32'h0000_0000);
    rd(8'h10, 32'h0000_0008);
  endtask : t_d3hot
  task automatic pme(input logic [ND-1:0] m, input logic [ND-1:0] e);
    @(posedge mclk) hp_event <= m;
    @(posedge mclk) hp_event <= '0;
    @(posedge mclk) chk(32'(pme_tx), 32'(e));
  endtask : pme
  task automatic t_pme;
    int n;
    wr(8'h24, 32'h0000_0002);
    pme(6'h02, 6'h02);
    watch(500, 6'h02, n);
    chk(32'(n > 0), 32'h1);
    wr(8'h20, 32'h0000_8000);
    // A resend may still launch on the clearing edge
    @(posedge mclk);
    watch(500, 6'h02, n);
    chk(32'(n), 32'h0);
    wr(8'h30, 32'h0000_0010);
    wr(8'h30, 32'h0000_0003);
    @(posedge mclk) power_removed <= 7'h08;
    pme(6'h04, 6'h00);
    wr(8'h40, 32'h0000_0010);
    wr(8'h40, 32'h0000_0003);
    pme(6'h08, 6'h08);
    wr(8'h40, 32'h0000_8000);
    pme(6'h08, 6'h08);
  endtask : t_pme
  task automatic t_turnoff;
    int n;
    wr(8'h58, 32'h0000_0002);
    wr(8'h00, 32'h0000_0010);
    wr(8'h00, 32'h0000_0003);
    @(posedge mclk) begin
      ack_dly <= {8'h00, 8'h00, 8'h05, 8'h0c, 8'h03, 8'h14};
      dn_active <= 6'h1f;
      turnoff_rx <= 1'b1;
    end
    @(posedge mclk) turnoff_rx <= 1'b0;
    @(posedge mclk) chk(32'(turnoff_tx), 32'h0000_001f);
    for (n = 0; n < 600 && up_ack_tx !== 1'b1; n++)
      @(posedge mclk);
    if (n >= 600) begin
      err_count++;
      finish_test();
    end
    chk(32'(n > 100), 32'h1);
    chk(32'(dn_l23), 32'h0000_001f);
    @(posedge mclk) chk(32'(up_l23), 32'h1);
    chk(32'(switch_low), 32'h1);
    tlp(3'h0, 1'b0, K_REQ, 3'h1, X_DROP);
    wr(8'h00, 32'h0000_0000);
    rd(8'h00, 32'h0000_0008);
    chk(32'(switch_low), 32'h0);
    pme(6'h01, 6'h01);
  endtask : t_turnoff
  task automatic t_abandon;
    int n;
    do_reset();
    rd(8'h88, 32'h0000_0000);
    @(posedge mclk) begin
      ack_dly <= {8'h00, 8'h00, 8'h00, 8'h00, 8'h28, 8'h03};
      dn_active <= 6'h03;
      turnoff_rx <= 1'b1;
    end
    @(posedge mclk) turnoff_rx <= 1'b0;
    repeat (10) @(posedge mclk);
    chk(32'(dn_l23), 32'h0000_0001);
    tlp(3'h0, 1'b0, K_REQ, 3'h1, X_ROUTE);
    chk(32'(dn_retrain), 32'h0000_0001);
    watch(60, 6'h00, n);
    chk(32'(n), 32'h0);
    chk(32'(dn_l23[1]), 32'h1);
  endtask : t_abandon
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    do_reset();
    t_regs();
    t_d3hot();
    t_pme();
    t_turnoff();
    t_abandon();
    finish_test();
  end
endmodule : testbench
